/* File: rtl/smc_pkg.sv */
// Constants for the synthesizer modulator configuration decode.
// Assumes 24-bit program words shifted in MSB first, address in bits 3:0.
package smc_pkg;
	localparam int unsigned WORD_W        = 24;
	localparam int unsigned ADDR_W        = 4;
	localparam int unsigned FRAC_LOW_W    = 12;
	localparam int unsigned FRAC_UP_W     = 10;
	localparam int unsigned FRAC_W        = 22;

	// Address codes in the low bits of a word
	localparam logic [3:0] ADDR_CONFIG_WORD    = 4'h9;
	localparam logic [3:0] ADDR_EXTENSION_WORD = 4'hb;
	// Main frequency word is recognised by bit 0 alone
	localparam int unsigned MAIN_WORD_BIT      = 0;
	localparam logic        MAIN_WORD_CODE     = 1'h0;

	// Config word field positions
	localparam int unsigned AUTO_WAKE_BIT      = 23;
	localparam int unsigned SPREAD_LSB         = 16;
	localparam int unsigned ORDER_LSB          = 14;
	localparam int unsigned DOUBLER_BIT        = 12;
	localparam int unsigned BUF_OUT_BIT        = 11;

	// Extension word field positions
	localparam int unsigned DEN_UPPER_LSB      = 14;
	localparam int unsigned NUM_UPPER_LSB      = 4;

	// Modulator order codes
	localparam logic [1:0] ORDER_FOURTH        = 2'h0;
	localparam logic [1:0] ORDER_OFF           = 2'h1;
	localparam logic [1:0] ORDER_SECOND        = 2'h2;
	localparam logic [1:0] ORDER_THIRD         = 2'h3;

	// Dither level codes
	localparam logic [1:0] SPREAD_NONE         = 2'h0;
	localparam logic [1:0] SPREAD_WEAK         = 2'h1;
	localparam logic [1:0] SPREAD_STRONG       = 2'h2;
	localparam logic [1:0] SPREAD_RESERVED     = 2'h3;

	// Values after reset
	localparam logic [23:0] RESET_WORD         = 24'h000000;
	localparam logic [1:0]  RESET_ORDER        = 2'h0;
	localparam logic [1:0]  RESET_SPREAD       = 2'h0;
	localparam logic [9:0]  RESET_UPPER        = 10'h000;
	localparam logic        RESET_SLEEP        = 1'h1;
endpackage

/* File: rtl/smc_config.sv */
// Serial configuration decode for the fractional-N modulator settings.
// Assumes pins are asynchronous to clk and the serial clock runs well
// below a quarter of clk; lower fraction bits come from other registers.
//
// Function
// - Buffer pin floats when disabled, else drives reference
// - Doubler off: both counters see plain reference
// - Doubler on: RF counter sees doubled reference
// - Order code 0/2/3 gives fourth/second/third order
// - Order code 1 switches the modulator off
// - Dither code: none, weak, strong, reserved
// - Auto wake: main word write clears sleep bits
// - Chip enable low suppresses auto wake
// - Narrow mode: 12-bit numerator, upper bits ignored
// - Wide mode: upper ten numerator bits joined above
// - Wide mode widens denominator likewise, narrow ignores
`timescale 1ns/1ps
module smc_config
	import smc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              prog_clock_pin,
	input  wire logic              prog_data_pin,
	input  wire logic              prog_latch_pin,
	input  wire logic              chip_enable_pin,
	input  wire logic              reference_input_pin,
	input  wire logic              extended_width_select,
	input  wire logic [11:0]       frac_numerator_lower,
	input  wire logic [11:0]       frac_denominator_lower,
	input  wire logic              sleep_write,
	input  wire logic              rf_sleep_value,
	input  wire logic              if_sleep_value,
	output logic                   reference_buffer_pin_out,
	output logic                   reference_buffer_pin_oe_n,
	output logic                   rf_ref_tick,
	output logic                   if_ref_tick,
	output logic                   modulator_enable,
	output logic [2:0]             modulator_order,
	output logic                   dither_enable,
	output logic                   dither_strong,
	output logic                   rf_loop_sleep,
	output logic                   if_loop_sleep,
	output logic [21:0]            frac_numerator,
	output logic [21:0]            frac_denominator
);

	// Two-flop synchronisers; clock, latch and reference add one stage for edge detection
	logic [2:0] sclk_sync;
	logic [1:0] sdat_sync;
	logic [2:0] sle_sync;
	logic [1:0] ce_sync;
	logic [2:0] ref_sync;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_sync <= 3'h0;
			sdat_sync <= 2'h0;
			sle_sync  <= 3'h0;
			ce_sync   <= 2'h0;
			ref_sync  <= 3'h0;
		end else begin
			sclk_sync <= {sclk_sync[1:0], prog_clock_pin};
			sdat_sync <= {sdat_sync[0], prog_data_pin};
			sle_sync  <= {sle_sync[1:0], prog_latch_pin};
			ce_sync   <= {ce_sync[0], chip_enable_pin};
			ref_sync  <= {ref_sync[1:0], reference_input_pin};
		end
	end

	// Edges are taken from stages two and three only
	logic sclk_rise;
	logic latch_rise;
	logic ref_rise;
	logic ref_fall;
	assign sclk_rise  = sclk_sync[1] & ~sclk_sync[2];
	assign latch_rise = sle_sync[1] & ~sle_sync[2];
	assign ref_rise   = ref_sync[1] & ~ref_sync[2];
	assign ref_fall   = ~ref_sync[1] & ref_sync[2];

	// Program state
	logic [23:0] shift_word;
	logic        auto_wake_on_word_zero;
	logic [1:0]  spur_spread_level;
	logic [1:0]  modulator_order_select;
	logic        ref_doubler_enable;
	logic        ref_buffer_out_enable;
	logic [9:0]  frac_numerator_upper;
	logic [9:0]  frac_denominator_upper;
	logic        rf_sleep;
	logic        if_sleep;

	logic [23:0] next_shift_word;
	logic        next_auto_wake;
	logic [1:0]  next_spread;
	logic [1:0]  next_order;
	logic        next_doubler;
	logic        next_buf_out;
	logic [9:0]  next_num_upper;
	logic [9:0]  next_den_upper;
	logic        next_rf_sleep;
	logic        next_if_sleep;
	logic        wake;

	// Shift on serial clock rise, decode the word on latch rise
	always_comb begin
		next_shift_word = shift_word;
		next_auto_wake  = auto_wake_on_word_zero;
		next_spread     = spur_spread_level;
		next_order      = modulator_order_select;
		next_doubler    = ref_doubler_enable;
		next_buf_out    = ref_buffer_out_enable;
		next_num_upper  = frac_numerator_upper;
		next_den_upper  = frac_denominator_upper;
		next_rf_sleep   = rf_sleep;
		next_if_sleep   = if_sleep;
		wake            = 1'b0;
		if (sclk_rise) begin
			next_shift_word = {shift_word[22:0], sdat_sync[1]};
		end
		if (latch_rise) begin
			if (shift_word[3:0] == ADDR_CONFIG_WORD) begin
				next_auto_wake = shift_word[AUTO_WAKE_BIT];
				next_spread    = shift_word[SPREAD_LSB +: 2];
				next_order     = shift_word[ORDER_LSB +: 2];
				next_doubler   = shift_word[DOUBLER_BIT];
				next_buf_out   = shift_word[BUF_OUT_BIT];
			end
			if (shift_word[3:0] == ADDR_EXTENSION_WORD) begin
				next_den_upper = shift_word[DEN_UPPER_LSB +: 10];
				next_num_upper = shift_word[NUM_UPPER_LSB +: 10];
			end
			// CE low blocks the wake even with the bit set
			if (shift_word[MAIN_WORD_BIT] == MAIN_WORD_CODE &&
			    auto_wake_on_word_zero && ce_sync[1]) begin
				wake = 1'b1;
			end
		end
		// Explicit sleep write takes effect first, then wake overrides
		if (sleep_write) begin
			next_rf_sleep = rf_sleep_value;
			next_if_sleep = if_sleep_value;
		end
		if (wake) begin
			next_rf_sleep = 1'b0;
			next_if_sleep = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_word             <= RESET_WORD;
			auto_wake_on_word_zero <= 1'b0;
			spur_spread_level      <= RESET_SPREAD;
			modulator_order_select <= RESET_ORDER;
			ref_doubler_enable     <= 1'b0;
			ref_buffer_out_enable  <= 1'b0;
			frac_numerator_upper   <= RESET_UPPER;
			frac_denominator_upper <= RESET_UPPER;
			rf_sleep               <= RESET_SLEEP;
			if_sleep               <= RESET_SLEEP;
		end else begin
			shift_word             <= next_shift_word;
			auto_wake_on_word_zero <= next_auto_wake;
			spur_spread_level      <= next_spread;
			modulator_order_select <= next_order;
			ref_doubler_enable     <= next_doubler;
			ref_buffer_out_enable  <= next_buf_out;
			frac_numerator_upper   <= next_num_upper;
			frac_denominator_upper <= next_den_upper;
			rf_sleep               <= next_rf_sleep;
			if_sleep               <= next_if_sleep;
		end
	end

	// Decoded outputs, all registered
	logic        next_buf_pin_out;
	logic        next_buf_pin_oe_n;
	logic        next_rf_tick;
	logic        next_if_tick;
	logic        next_mod_en;
	logic [2:0]  next_mod_order;
	logic        next_spur_spread_level_en;
	logic        next_spur_spread_level_strong;
	logic [21:0] next_num;
	logic [21:0] next_den;

	always_comb begin
		// Buffer copies the synchronised reference, so it lags by a few
		// clocks and cannot pass tones above half of clk
		next_buf_pin_oe_n = ~ref_buffer_out_enable;
		next_buf_pin_out  = ref_buffer_out_enable & ref_sync[1];
		// Doubling counts both reference edges for the RF counter
		next_if_tick = ref_rise;
		next_rf_tick = ref_doubler_enable ? (ref_rise | ref_fall)
		                                  : ref_rise;
		unique case (modulator_order_select)
			ORDER_FOURTH: begin
				next_mod_en    = 1'b1;
				next_mod_order = 3'h4;
			end
			ORDER_OFF: begin
				next_mod_en    = 1'b0;
				next_mod_order = 3'h0;
			end
			ORDER_SECOND: begin
				next_mod_en    = 1'b1;
				next_mod_order = 3'h2;
			end
			ORDER_THIRD: begin
				next_mod_en    = 1'b1;
				next_mod_order = 3'h3;
			end
		endcase
		// Reserved dither code behaves as dithering off
		unique case (spur_spread_level)
			SPREAD_NONE: begin
				next_spur_spread_level_en     = 1'b0;
				next_spur_spread_level_strong = 1'b0;
			end
			SPREAD_WEAK: begin
				next_spur_spread_level_en     = 1'b1;
				next_spur_spread_level_strong = 1'b0;
			end
			SPREAD_STRONG: begin
				next_spur_spread_level_en     = 1'b1;
				next_spur_spread_level_strong = 1'b1;
			end
			SPREAD_RESERVED: begin
				next_spur_spread_level_en     = 1'b0;
				next_spur_spread_level_strong = 1'b0;
			end
		endcase
		if (extended_width_select) begin
			next_num = {frac_numerator_upper, frac_numerator_lower};
			next_den = {frac_denominator_upper,
			            frac_denominator_lower};
		end else begin
			next_num = {10'h000, frac_numerator_lower};
			next_den = {10'h000, frac_denominator_lower};
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reference_buffer_pin_out  <= 1'b0;
			reference_buffer_pin_oe_n <= 1'b1;
			rf_ref_tick               <= 1'b0;
			if_ref_tick               <= 1'b0;
			modulator_enable          <= 1'b0;
			modulator_order           <= 3'h0;
			dither_enable             <= 1'b0;
			dither_strong             <= 1'b0;
			frac_numerator            <= 22'h000000;
			frac_denominator          <= 22'h000000;
		end else begin
			reference_buffer_pin_out  <= next_buf_pin_out;
			reference_buffer_pin_oe_n <= next_buf_pin_oe_n;
			rf_ref_tick               <= next_rf_tick;
			if_ref_tick               <= next_if_tick;
			modulator_enable          <= next_mod_en;
			modulator_order           <= next_mod_order;
			dither_enable             <= next_spur_spread_level_en;
			dither_strong             <= next_spur_spread_level_strong;
			frac_numerator            <= next_num;
			frac_denominator          <= next_den;
		end
	end

	assign rf_loop_sleep = rf_sleep;
	assign if_loop_sleep = if_sleep;

endmodule // smc_config

/* File: tb/smc_host_model.sv */
// Host side of the serial port: shifts 24-bit words MSB first.
// Assumes clk is the bench clock; pins move on its falling edge.
`timescale 1ns/1ps
module smc_host_model (
	input  wire logic clk,
	output logic      prog_clock_pin,
	output logic      prog_data_pin,
	output logic      prog_latch_pin
);
	// Serial clock idles low outside words
	initial begin
		prog_clock_pin = 1'h0;
		prog_data_pin  = 1'h0;
		prog_latch_pin = 1'h0;
	end

	// Five cycles a level keeps clear of the two-flop sync
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			@(negedge clk) prog_data_pin = w[i];
			repeat (5) @(negedge clk);
			prog_clock_pin = 1'h1;
			repeat (5) @(negedge clk);
			prog_clock_pin = 1'h0;
		end
		prog_data_pin = ~w[0]; // Stale data must not look valid
		repeat (5) @(negedge clk);
		prog_latch_pin = 1'h1;
		repeat (6) @(negedge clk);
		prog_latch_pin = 1'h0;
		repeat (8) @(negedge clk);
	endtask
endmodule // smc_host_model

/* File: tb/smc_config_checker.sv */
// Port-level properties of the modulator configuration decode.
// Assumes binding to smc_config; sees only its ports.
`timescale 1ns/1ps
module smc_config_checker (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        chip_enable_pin,
	input wire logic        extended_width_select,
	input wire logic [11:0] frac_numerator_lower,
	input wire logic [11:0] frac_denominator_lower,
	input wire logic        sleep_write,
	input wire logic        reference_buffer_pin_out,
	input wire logic        reference_buffer_pin_oe_n,
	input wire logic        modulator_enable,
	input wire logic [2:0]  modulator_order,
	input wire logic        dither_enable,
	input wire logic        dither_strong,
	input wire logic        rf_loop_sleep,
	input wire logic        if_loop_sleep,
	input wire logic [21:0] frac_numerator,
	input wire logic [21:0] frac_denominator
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [3:0] ce_low_cnt;

	// Enable must be low well past the sync before wake is barred
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			ce_low_cnt <= 4'h0;
		else if (chip_enable_pin)
			ce_low_cnt <= 4'h0;
		else if (ce_low_cnt != 4'hf)
			ce_low_cnt <= ce_low_cnt + 4'h1;
	end

	buf_float_a: assert property (
		reference_buffer_pin_oe_n |-> !reference_buffer_pin_out)
		else $error("buffer driven while floating");
	order_code_a: assert property (
		modulator_enable |-> modulator_order inside {3'h2, 3'h3, 3'h4})
		else $error("bad modulator order");
	order_off_a: assert property (
		!modulator_enable |-> modulator_order == 3'h0)
		else $error("order shown while modulator off");
	dither_pair_a: assert property (
		dither_strong |-> dither_enable)
		else $error("strong dither without enable");
	wake_both_a: assert property (
		$fell(rf_loop_sleep) && !$past(sleep_write) |-> !if_loop_sleep)
		else $error("loops woke apart");
	ce_block_a: assert property (
		ce_low_cnt > 4'h4 && !sleep_write && rf_loop_sleep |=> rf_loop_sleep)
		else $error("woke with enable low");
	num_narrow_a: assert property (
		$past(resetn) && !$past(extended_width_select) |->
		frac_numerator == {10'h000, $past(frac_numerator_lower)})
		else $error("narrow numerator wrong");
	den_narrow_a: assert property (
		$past(resetn) && !$past(extended_width_select) |->
		frac_denominator == {10'h000, $past(frac_denominator_lower)})
		else $error("narrow denominator wrong");

	cover property (!modulator_enable);
	cover property (dither_strong);
	cover property ($fell(rf_loop_sleep));
endmodule // smc_config_checker

bind smc_config smc_config_checker u_smc_config_checker (.clk, .resetn,
	.chip_enable_pin, .extended_width_select, .frac_numerator_lower,
	.frac_denominator_lower, .sleep_write, .reference_buffer_pin_out,
	.reference_buffer_pin_oe_n, .modulator_enable, .modulator_order,
	.dither_enable, .dither_strong, .rf_loop_sleep, .if_loop_sleep,
	.frac_numerator, .frac_denominator);

/* File: tb/test_synth_modulator_config.sv */
// Self-checking bench for the modulator configuration decode.
// Assumes the host model drives the serial pins; bench drives the rest.
`timescale 1ns/1ps
module test_synth_modulator_config
	import smc_pkg::*;
;
	logic        clk, resetn, ce, ref_in, ext, sw, rf_sv, if_sv;
	logic        p_clk, p_dat, p_lat, b_out, b_oe_n, rf_t, if_t;
	logic        m_en, d_en, d_st, rf_sl, if_sl;
	logic [2:0]  m_ord;
	logic [11:0] n_lo, d_lo;
	logic [21:0] num, den;
	int          n_mismatch, checked, rf_n, if_n;

	smc_host_model u_smc_host_model (.clk(clk), .prog_clock_pin(p_clk),
		.prog_data_pin(p_dat), .prog_latch_pin(p_lat));
	smc_config u_smc_config (.clk(clk), .resetn(resetn),
		.prog_clock_pin(p_clk), .prog_data_pin(p_dat),
		.prog_latch_pin(p_lat), .chip_enable_pin(ce),
		.reference_input_pin(ref_in), .extended_width_select(ext),
		.frac_numerator_lower(n_lo), .frac_denominator_lower(d_lo),
		.sleep_write(sw), .rf_sleep_value(rf_sv), .if_sleep_value(if_sv),
		.reference_buffer_pin_out(b_out),
		.reference_buffer_pin_oe_n(b_oe_n), .rf_ref_tick(rf_t),
		.if_ref_tick(if_t), .modulator_enable(m_en),
		.modulator_order(m_ord), .dither_enable(d_en),
		.dither_strong(d_st), .rf_loop_sleep(rf_sl),
		.if_loop_sleep(if_sl), .frac_numerator(num),
		.frac_denominator(den));

	// 50 MHz clock
	always #10 clk = ~clk;
	// Tick counts give the reference rates
	always @(posedge clk) begin
		rf_n += int'(rf_t === 1'h1);
		if_n += int'(if_t === 1'h1);
	end

	task automatic chk(string s, logic [23:0] exp, logic [23:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", s, exp, got);
		end
	endtask

	function automatic logic [23:0] cfg(logic aw, logic [1:0] sp,
		logic [1:0] od, logic dbl, logic bo);
		return {aw, 5'h00, sp, od, 1'h0, dbl, bo, 7'h00, ADDR_CONFIG_WORD};
	endfunction

	// Each order and dither code in turn
	task automatic t_codes();
		logic [2:0] ord [4] = '{3'h4, 3'h0, 3'h2, 3'h3};
		for (int c = 0; c < 4; c++) begin
			u_smc_host_model.send(cfg(1'h0, 2'(c), 2'(c), 1'h0, 1'h0));
			chk("order", {21'h0, ord[c]}, {21'h0, m_ord});
			chk("mod_en", 24'(c != 1), {23'h0, m_en});
			chk("dither", 24'({c == 1 || c == 2, c == 2}), {22'h0, d_en, d_st});
		end
	endtask

	// Doubler and buffer on, then both off
	task automatic t_ref();
		for (int m = 1; m >= 0; m--) begin
			u_smc_host_model.send(cfg(1'h0, 2'h0, 2'h0, m[0], m[0]));
			chk("oe_n", {23'h0, ~m[0]}, {23'h0, b_oe_n});
			rf_n = 0;
			if_n = 0;
			repeat (4) begin
				@(negedge clk) ref_in = 1'h1;
				repeat (8) @(negedge clk);
				chk("buf", {23'h0, m[0]}, {23'h0, b_out});
				repeat (2) @(negedge clk);
				ref_in = 1'h0;
				repeat (10) @(negedge clk);
			end
			chk("rf_ticks", 24'(4 * (m + 1)), 24'(rf_n));
			chk("if_ticks", 24'h4, 24'(if_n));
		end
	endtask

	// Auto wake barred while enable low, then allowed
	task automatic t_wake();
		u_smc_host_model.send(cfg(1'h1, 2'h0, 2'h0, 1'h0, 1'h0));
		for (int e = 0; e < 2; e++) begin
			@(negedge clk) {sw, rf_sv, if_sv, ce} = {3'h7, e[0]};
			@(negedge clk) sw = 1'h0;
			u_smc_host_model.send(24'h5a5a50);
			chk("sleep", {22'h0, ~e[0], ~e[0]}, {22'h0, rf_sl, if_sl});
		end
		// Wake bit clear: main word must leave unequal sleep bits alone
		u_smc_host_model.send(cfg(1'h0, 2'h0, 2'h0, 1'h0, 1'h0));
		@(negedge clk) {sw, rf_sv, if_sv} = 3'h5;
		@(negedge clk) sw = 1'h0;
		u_smc_host_model.send(24'h5a5a50);
		chk("no_wake", 24'h1, {22'h0, rf_sl, if_sl});
	endtask

	// Upper fraction bits apply in wide mode only
	task automatic t_ext();
		@(negedge clk) {n_lo, d_lo} = {12'h9c3, 12'h3e7};
		u_smc_host_model.send({10'h2a5, 10'h15a, ADDR_EXTENSION_WORD});
		for (int w = 0; w < 2; w++) begin
			@(negedge clk) ext = w[0];
			repeat (3) @(negedge clk);
			chk("num", {2'h0, w[0] ? 10'h15a : 10'h0, 12'h9c3}, {2'h0, num});
			chk("den", {2'h0, w[0] ? 10'h2a5 : 10'h0, 12'h3e7}, {2'h0, den});
		end
	endtask

	task automatic results();
		if (n_mismatch == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		{clk, resetn, ce, ref_in, ext, sw, rf_sv, if_sv} = 8'h20;
		{n_lo, d_lo} = 24'h0;
		repeat (20) @(negedge clk);
		resetn = 1'h1;
		repeat (3) @(negedge clk);
		chk("reset", 24'hf, {20'h0, rf_sl, if_sl, b_oe_n, m_en});
		t_codes();
		t_ref();
		t_wake();
		t_ext();
		results();
	end

	// Run should end near 3600 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		results();
	end
endmodule // test_synth_modulator_config
